// file: rtl/line_status_regs.v
// Line status, interrupt event and error count registers of the line interface

`include "line_status_map.vh"

// Qualification counts are parameters so a bench can shorten them
module line_status_regs #(
	parameter [`QUAL_WIDTH-1:0] QUAL_SHORT_CYCLES = `QUAL_SHORT_CYCLES_DEF, // 40 ms
	parameter [`QUAL_WIDTH-1:0] QUAL_LONG_CYCLES = `QUAL_LONG_CYCLES_DEF // 5.1 s
) (
	input wire i_clk, // Master clock, 40 MHz
	input wire i_nrst, // Asynchronous reset, active low
	input wire [7:0] i_addr, // Register address
	input wire i_rd, // Read strobe, one cycle
	input wire i_wr, // Write strobe, one cycle
	input wire [7:0] i_wdata, // Write data
	output wire [7:0] o_rdata, // Read data, valid the cycle after i_rd
	output wire o_int_req, // Interrupt request, active high
	output wire o_remote_loop_active, // Remote loopback running
	input wire i_auto_remote_loop_enable, // Longer qualification time when high
	input wire i_equalizer_out_of_range, // Equalizer out of range
	input wire i_activate_pattern_ok, // Activate pattern seen with low error rate
	input wire i_deactivate_pattern_ok, // Deactivate pattern seen with low error rate
	input wire i_test_sequence_locked, // Receiver locked to test sequence
	input wire i_transmit_clock_input, // Transmit clock pin, asynchronous
	input wire i_driver_short, // Line driver short circuit
	input wire i_alarm_indication, // Alarm indication signal received
	input wire i_signal_loss, // Loss of signal on the receive line
	input wire [4:0] i_line_attenuation_code, // Measured attenuation code
	input wire i_amplitude_overflow, // Waveform generator overflow pulse
	input wire i_jitter_overflow, // Jitter buffer overflow pulse
	input wire i_jitter_underflow, // Jitter buffer underflow pulse
	input wire i_sequence_logic_error, // Test sequence bit error pulse
	input wire i_excess_zeros, // Excess zeros pulse
	input wire i_code_violation, // Code violation pulse
	input wire i_one_second_tick // One second timer expiry pulse
);

	// Event edge detect: rising only, or any change when select is set
	// A set select bit adds the falling edge to the rising one
	function [7:0] edge_event;
		input [7:0] cur;
		input [7:0] prev;
		input [7:0] sel;
		begin
			edge_event = (cur & ~prev) | (sel & ~cur & prev);
		end
	endfunction

	// Control registers written by the host
	// Error control bit 0 is the transfer trigger, bits 3:2 the error type
	reg [7:0] error_control_reg; // Error select and transfer bit
	reg [7:0] event_mask_a_reg; // Masks for events A
	reg [7:0] event_mask_b_reg; // Masks for events B
	reg [7:0] edge_select_reg; // Edge select for events A

	// Status and event state
	reg [7:0] status_prev_reg; // Status A from the last cycle
	reg [7:0] events_a_reg; // Latched events A
	reg [7:0] events_a_next;
	reg [7:0] events_b_reg; // Latched events B
	reg [7:0] events_b_next;
	reg [7:0] rdata_reg; // Read data output
	reg [7:0] rdata_next;
	reg int_req_reg; // Interrupt request output
	reg remote_loop_reg; // Remote loopback state

	// Code qualification state
	reg [`QUAL_WIDTH-1:0] activate_cnt_reg; // Cycles with activate pattern
	reg [`QUAL_WIDTH-1:0] deactivate_cnt_reg; // Cycles with deactivate pattern
	reg activate_flag_reg; // Qualified activate code
	reg deactivate_flag_reg; // Qualified deactivate code
	reg activate_prev_reg; // Activate flag last cycle
	reg deactivate_prev_reg; // Deactivate flag last cycle

	// Transmit clock loss state
	reg tx_sync1_reg; // First synchroniser stage
	reg tx_sync2_reg; // Second synchroniser stage
	reg tx_sync3_reg; // Third synchroniser stage
	reg tx_level_reg; // Accepted transmit clock level
	reg [`TX_LOSS_WIDTH-1:0] tx_idle_cnt_reg; // Cycles since last toggle
	reg tx_loss_flag_reg; // Transmit clock lost

	// Error counter state
	reg [15:0] run_count_reg; // Running error counter
	reg [15:0] count_hold_reg; // Count bytes seen by the host
	reg transfer_prev_reg; // Transfer bit last cycle

	// Combinational helpers
	wire [`QUAL_WIDTH-1:0] qual_limit; // Qualification time in cycles
	wire [7:0] status_a; // Status register A
	wire [7:0] status_b; // Status register B
	wire [7:0] events_a_new; // Newly raised events A
	wire [7:0] events_b_new; // Newly raised events B
	wire read_events_a; // Host reads events A
	wire read_events_b; // Host reads events B
	wire [1:0] err_sel; // Counted error type
	wire transfer_rise; // Transfer bit went 0 to 1
	reg [1:0] err_inc; // Errors to count this cycle
	wire [16:0] count_sum; // Counter plus increment
	wire count_overflow; // Counter wrapped this cycle

	// Both code flags share one time base chosen by the auto loop input
	assign qual_limit = i_auto_remote_loop_enable ? QUAL_LONG_CYCLES
		: QUAL_SHORT_CYCLES;

	// Status A assembly, one source per bit
	// Real-time levels pass straight through; only the timed flags are registered
	assign status_a[`BIT_EQUALIZER] = i_equalizer_out_of_range;
	assign status_a[`BIT_ACTIVATE] = activate_flag_reg;
	assign status_a[`BIT_DEACTIVATE] = deactivate_flag_reg;
	assign status_a[`BIT_SEQ_SYNC] = i_test_sequence_locked;
	assign status_a[`BIT_TX_CLOCK_LOSS] = tx_loss_flag_reg;
	assign status_a[`BIT_DRIVER_FAULT] = i_driver_short;
	assign status_a[`BIT_ALARM] = i_alarm_indication;
	assign status_a[`BIT_SIGNAL_LOSS] = i_signal_loss;

	// Status B: reserved zero bits, loop state and attenuation
	assign status_b = {2'h0, remote_loop_reg, i_line_attenuation_code};

	// Events raised only where the mask bit is clear
	// Events B come from one-cycle pulses and take no edge select
	assign events_a_new = edge_event(status_a, status_prev_reg, edge_select_reg)
		& ~event_mask_a_reg;
	assign events_b_new = {i_amplitude_overflow, i_jitter_overflow, i_jitter_underflow,
		i_sequence_logic_error, i_excess_zeros, i_code_violation, i_one_second_tick,
		count_overflow} & ~event_mask_b_reg;

	// Event registers are cleared by a host read of their address
	assign read_events_a = i_rd && (i_addr == `ADDR_EVENTS_A);
	assign read_events_b = i_rd && (i_addr == `ADDR_EVENTS_B);

	// Read clears, but an event in the same cycle survives the clear
	always @* begin
		events_a_next = (events_a_reg & ~{8{read_events_a}}) | events_a_new;
		events_b_next = (events_b_reg & ~{8{read_events_b}}) | events_b_new;
	end

	// Error selection and counter arithmetic
	// The transfer acts on the rising edge of the register bit, so the
	// host must write the bit low again before the next transfer
	assign err_sel = error_control_reg[`ERR_SEL_MSB:`ERR_SEL_LSB];
	assign transfer_rise = error_control_reg[`BIT_COUNT_TRANSFER] && !transfer_prev_reg;

	// Pick the counted error type
	// Both errors in one cycle add two in the combined mode
	always @* begin
		case (err_sel)
			`ERR_SEL_SEQ: err_inc = {1'b0, i_sequence_logic_error};
			`ERR_SEL_EXZ: err_inc = {1'b0, i_excess_zeros};
			`ERR_SEL_CV: err_inc = {1'b0, i_code_violation};
			`ERR_SEL_BOTH: err_inc = {1'b0, i_code_violation} + {1'b0, i_excess_zeros};
			default: err_inc = 2'h0;
		endcase
	end

	// One bit wider so that a wrap shows up as an overflow event
	// No overflow is reported in the cycle the counter is zeroed
	assign count_sum = {1'b0, run_count_reg} + {15'h0000, err_inc};
	assign count_overflow = count_sum[16] && !transfer_rise;

	// Read data mux, unmapped addresses read zero
	// The read edge captures the value before the event clear lands
	always @* begin
		case (i_addr)
			`ADDR_ERROR_CONTROL: rdata_next = error_control_reg;
			`ADDR_EVENT_MASK_A: rdata_next = event_mask_a_reg;
			`ADDR_EVENT_MASK_B: rdata_next = event_mask_b_reg;
			`ADDR_EDGE_SELECT: rdata_next = edge_select_reg;
			`ADDR_STATUS_A: rdata_next = status_a;
			`ADDR_STATUS_B: rdata_next = status_b;
			`ADDR_EVENTS_A: rdata_next = events_a_reg;
			`ADDR_EVENTS_B: rdata_next = events_b_reg;
			`ADDR_COUNT_LOW: rdata_next = count_hold_reg[7:0];
			`ADDR_COUNT_HIGH: rdata_next = count_hold_reg[15:8];
			default: rdata_next = `BYTE_ZERO;
		endcase
	end

	// Host writes to control registers
	// Writes to read-only addresses leave every register unchanged
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			error_control_reg <= `BYTE_ZERO;
			event_mask_a_reg <= `MASK_RESET;
			event_mask_b_reg <= `MASK_RESET;
			edge_select_reg <= `EDGE_SELECT_RESET;
		end else if (i_wr) begin
			case (i_addr)
				`ADDR_ERROR_CONTROL: error_control_reg <= i_wdata;
				`ADDR_EVENT_MASK_A: event_mask_a_reg <= i_wdata;
				`ADDR_EVENT_MASK_B: event_mask_b_reg <= i_wdata;
				`ADDR_EDGE_SELECT: edge_select_reg <= i_wdata;
				default: error_control_reg <= error_control_reg;
			endcase
		end
	end

	// Event latches, read data and interrupt request
	// The request uses the next event values, so it rises with the event
	// bit and falls on the very read that clears the last one
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			status_prev_reg <= `BYTE_ZERO;
			events_a_reg <= `BYTE_ZERO;
			events_b_reg <= `BYTE_ZERO;
			rdata_reg <= `BYTE_ZERO;
			int_req_reg <= 1'b0;
		end else begin
			status_prev_reg <= status_a;
			events_a_reg <= events_a_next;
			events_b_reg <= events_b_next;
			if (i_rd) begin
				rdata_reg <= rdata_next;
			end
			int_req_reg <= (|events_a_next) || (|events_b_next);
		end
	end

	// Activate and deactivate code qualification timers
	// Each counter saturates at the limit while its pattern holds;
	// any break in the clean pattern starts the count again
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			activate_cnt_reg <= {`QUAL_WIDTH{1'b0}};
			deactivate_cnt_reg <= {`QUAL_WIDTH{1'b0}};
			activate_flag_reg <= 1'b0;
			deactivate_flag_reg <= 1'b0;
		end else begin
			// Flag drops as soon as the clean pattern is gone
			if (!i_activate_pattern_ok) begin
				activate_cnt_reg <= {`QUAL_WIDTH{1'b0}};
				activate_flag_reg <= 1'b0;
			end else if (activate_cnt_reg >= qual_limit) begin
				activate_flag_reg <= 1'b1;
			end else begin
				activate_cnt_reg <= activate_cnt_reg + 1'b1;
			end
			// Same qualification for the deactivate code
			if (!i_deactivate_pattern_ok) begin
				deactivate_cnt_reg <= {`QUAL_WIDTH{1'b0}};
				deactivate_flag_reg <= 1'b0;
			end else if (deactivate_cnt_reg >= qual_limit) begin
				deactivate_flag_reg <= 1'b1;
			end else begin
				deactivate_cnt_reg <= deactivate_cnt_reg + 1'b1;
			end
		end
	end

	// Remote loopback follows rising edges of the two code flags
	// A flag that stays high changes nothing after its rising edge
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			activate_prev_reg <= 1'b0;
			deactivate_prev_reg <= 1'b0;
			remote_loop_reg <= 1'b0;
		end else begin
			activate_prev_reg <= activate_flag_reg;
			deactivate_prev_reg <= deactivate_flag_reg;
			// Deactivate wins when both rise together
			if (deactivate_flag_reg && !deactivate_prev_reg) begin
				remote_loop_reg <= 1'b0;
			end else if (activate_flag_reg && !activate_prev_reg) begin
				remote_loop_reg <= 1'b1;
			end
		end
	end

	// Transmit clock synchroniser and idle counter
	// The pin is asynchronous: three stages guard against metastability,
	// and two agreeing stages filter a single short glitch
	// The idle counter stops once the loss flag is set, so it cannot wrap
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tx_sync1_reg <= 1'b0;
			tx_sync2_reg <= 1'b0;
			tx_sync3_reg <= 1'b0;
			tx_level_reg <= 1'b0;
			tx_idle_cnt_reg <= {`TX_LOSS_WIDTH{1'b0}};
			tx_loss_flag_reg <= 1'b0;
		end else begin
			tx_sync1_reg <= i_transmit_clock_input;
			tx_sync2_reg <= tx_sync1_reg;
			tx_sync3_reg <= tx_sync2_reg;
			// A toggle counts once the last two stages agree on a new level
			if ((tx_sync2_reg == tx_sync3_reg) && (tx_sync3_reg != tx_level_reg)) begin
				tx_level_reg <= tx_sync3_reg;
				tx_idle_cnt_reg <= {`TX_LOSS_WIDTH{1'b0}};
				tx_loss_flag_reg <= 1'b0;
			end else if (tx_idle_cnt_reg > `TX_LOSS_CYCLES) begin
				tx_loss_flag_reg <= 1'b1;
			end else begin
				tx_idle_cnt_reg <= tx_idle_cnt_reg + 1'b1;
			end
		end
	end

	// Running error counter and transfer to the host bytes
	// The held bytes change only on a transfer, so the host can read low
	// and high bytes as one coherent value between transfers
	// Errors that arrive in the transfer cycle itself are not counted
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			run_count_reg <= `COUNT_ZERO;
			count_hold_reg <= `COUNT_ZERO;
			transfer_prev_reg <= 1'b0;
		end else begin
			transfer_prev_reg <= error_control_reg[`BIT_COUNT_TRANSFER];
			if (transfer_rise) begin
				count_hold_reg <= run_count_reg;
				run_count_reg <= `COUNT_ZERO;
			end else begin
				run_count_reg <= count_sum[15:0];
			end
		end
	end

	// Outputs come straight from flip-flops
	assign o_rdata = rdata_reg;
	assign o_int_req = int_req_reg;
	assign o_remote_loop_active = remote_loop_reg;

endmodule

// file: rtl/line_status_map.vh
// Register offsets, field positions, reset values and timing constants of the status block
`ifndef LINE_STATUS_MAP_VH
`define LINE_STATUS_MAP_VH

// Clock rate of the master clock in kHz (40 MHz)
`define CLK_KHZ 40000

// Register offsets on the control interface
`define ADDR_ERROR_CONTROL 8'h13
`define ADDR_EVENT_MASK_A 8'h14
`define ADDR_EVENT_MASK_B 8'h15
`define ADDR_EDGE_SELECT 8'h16
`define ADDR_STATUS_A 8'h17
`define ADDR_STATUS_B 8'h18
`define ADDR_EVENTS_A 8'h19
`define ADDR_EVENTS_B 8'h1A
`define ADDR_COUNT_LOW 8'h1B
`define ADDR_COUNT_HIGH 8'h1C

// Reset values
`define MASK_RESET 8'hFF
`define EDGE_SELECT_RESET 8'h00
`define BYTE_ZERO 8'h00
`define COUNT_ZERO 16'h0000

// Status register A bit positions
`define BIT_EQUALIZER 7
`define BIT_ACTIVATE 6
`define BIT_DEACTIVATE 5
`define BIT_SEQ_SYNC 4
`define BIT_TX_CLOCK_LOSS 3
`define BIT_DRIVER_FAULT 2
`define BIT_ALARM 1
`define BIT_SIGNAL_LOSS 0

// Status register B fields
`define BIT_REMOTE_LOOP 5
`define ATTEN_MSB 4
`define ATTEN_LSB 0

// Events register B bit positions
`define BIT_AMPLITUDE_OVF 7
`define BIT_JITTER_OVF 6
`define BIT_JITTER_UDF 5
`define BIT_SEQ_ERROR 4
`define BIT_EXCESS_ZEROS 3
`define BIT_CODE_VIOLATION 2
`define BIT_ONE_SECOND 1
`define BIT_COUNT_OVF 0

// Error control register fields
`define ERR_SEL_MSB 3
`define ERR_SEL_LSB 2
`define BIT_COUNT_TRANSFER 0
`define ERR_SEL_SEQ 2'h0
`define ERR_SEL_EXZ 2'h1
`define ERR_SEL_CV 2'h2
`define ERR_SEL_BOTH 2'h3

// Code qualification times in ms
`define QUAL_SHORT_MS 40
`define QUAL_LONG_MS 5100
`define QUAL_WIDTH 28

// Qualification times in master clock cycles at 40 MHz: 40 ms and 5.1 s
`define QUAL_SHORT_CYCLES_DEF 28'h0186A00
`define QUAL_LONG_CYCLES_DEF 28'hC28CB00

// Transmit clock loss threshold in master clock cycles
`define TX_LOSS_CYCLES 7'h46
`define TX_LOSS_WIDTH 7

`endif

// file: tb/line_status_regs_properties.sv
// Port-level checker of the line status register block
module line_status_checks #(
	parameter [27:0] QUAL_SHORT_CYCLES = 28'h0000014 // Short qualification
) (
	input wire i_clk, // Master clock
	input wire i_nrst, // Reset, active low
	input wire [7:0] i_addr, // Address
	input wire i_rd, // Read strobe
	input wire i_wr, // Write strobe
	input wire [7:0] i_wdata, // Write data
	input wire [7:0] o_rdata, // Read data
	input wire o_int_req, // Interrupt request
	input wire o_remote_loop_active, // Loop state
	input wire i_activate_pattern_ok, // Activate pattern
	input wire i_deactivate_pattern_ok, // Deactivate pattern
	input wire i_alarm_indication, // Alarm level
	input wire i_signal_loss, // Signal loss level
	input wire [4:0] i_line_attenuation_code, // Attenuation
	input wire i_amplitude_overflow // Overflow pulse
);
	reg [1:0] quiet_reg; // Cycles the watched levels held still
	reg [5:0] lvl_reg; // Watched levels one cycle ago
	reg [7:0] mask_a_reg; // Shadow of mask A
	reg [7:0] mask_b_reg; // Shadow of mask B
	reg open_reg; // Some mask bit was ever cleared
	reg [27:0] act_reg; // Activate run length, saturating
	reg [27:0] deact_reg; // Deactivate run length, saturating
	wire [5:0] lvl = {i_alarm_indication, i_line_attenuation_code}; // Watched levels
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// Shadows masks, counts quiet cycles and pattern runs
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			quiet_reg <= 2'h0;
			lvl_reg <= 6'h00;
			mask_a_reg <= 8'hFF;
			mask_b_reg <= 8'hFF;
			open_reg <= 1'b0;
			act_reg <= 28'h0000000;
			deact_reg <= 28'h0000000;
		end else begin
			lvl_reg <= lvl;
			quiet_reg <= (lvl_reg != lvl) ? 2'h0 : quiet_reg + {1'b0, quiet_reg != 2'h3};
			if (i_wr && i_addr == 8'h14)
				mask_a_reg <= i_wdata;
			if (i_wr && i_addr == 8'h15)
				mask_b_reg <= i_wdata;
			if (i_wr && (i_addr == 8'h14 || i_addr == 8'h15) && i_wdata != 8'hFF)
				open_reg <= 1'b1;
			act_reg <= !i_activate_pattern_ok ? 28'h0000000 :
				act_reg + {27'h0000000, act_reg != QUAL_SHORT_CYCLES};
			deact_reg <= !i_deactivate_pattern_ok ? 28'h0000000 :
				deact_reg + {27'h0000000, deact_reg != QUAL_SHORT_CYCLES};
		end
	end
	property p_int_fall;
		$fell(o_int_req) |-> $past(i_rd) && ($past(i_addr) == 8'h19 || $past(i_addr) == 8'h1A);
	endproperty
	a_int_fall: assert property (p_int_fall)
		else $error("request dropped without an event read");
	property p_masked_quiet;
		!open_reg |-> !o_int_req;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet)
		else $error("request raised while all masked");
	property p_pulse_event;
		i_amplitude_overflow && !mask_b_reg[7] |-> ##[1:2] o_int_req;
	endproperty
	a_pulse_event: assert property (p_pulse_event)
		else $error("overflow pulse raised no request");
	property p_loss_event;
		$rose(i_signal_loss) && !mask_a_reg[0] |-> ##[1:3] o_int_req;
	endproperty
	a_loss_event: assert property (p_loss_event)
		else $error("signal loss rise raised no request");
	property p_loop_start;
		$rose(o_remote_loop_active) |-> act_reg == QUAL_SHORT_CYCLES;
	endproperty
	a_loop_start: assert property (p_loop_start)
		else $error("loopback started before qualification");
	property p_loop_end;
		$fell(o_remote_loop_active) |-> deact_reg == QUAL_SHORT_CYCLES;
	endproperty
	a_loop_end: assert property (p_loop_end)
		else $error("loopback ended before qualification");
	property p_status_b;
		i_rd && i_addr == 8'h18 && quiet_reg == 2'h3 |=> o_rdata[7:6] == 2'h0 &&
			o_rdata[5] == $past(o_remote_loop_active) &&
			o_rdata[4:0] == $past(i_line_attenuation_code);
	endproperty
	a_status_b: assert property (p_status_b)
		else $error("status B read wrong");
	property p_alarm;
		i_rd && i_addr == 8'h17 && quiet_reg == 2'h3 |=> o_rdata[1] == $past(i_alarm_indication);
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("alarm status bit wrong");
endmodule

bind line_status_regs line_status_checks #(.QUAL_SHORT_CYCLES(QUAL_SHORT_CYCLES)) u_checks (
	.i_clk, .i_nrst, .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata, .o_int_req,
	.o_remote_loop_active, .i_activate_pattern_ok, .i_deactivate_pattern_ok,
	.i_alarm_indication, .i_signal_loss, .i_line_attenuation_code, .i_amplitude_overflow
);

// file: tb/host_model.sv
// Host side of the register interface: strobed reads and writes
module host_model (
	input wire i_clk, // Master clock
	output reg [7:0] o_addr, // Address
	output reg o_rd, // Read strobe
	output reg o_wr, // Write strobe
	output reg [7:0] o_wdata, // Write data
	input wire [7:0] i_rdata // Read data
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		o_addr = 8'h00;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 8'h00;
	end
	// One write; afterwards the bus shows inverted junk, not stale values
	task wr_reg(input [7:0] a, input [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	// One read; data taken once the capturing edge has settled
	task rd_reg(input [7:0] a, output [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1 d = i_rdata;
	endtask
endmodule

// file: tb/line_status_regs_tb.sv
// Self-checking bench of the line status register block
module line_status_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [19:0] CODES = 20'h056DF; // Attenuation codes 00, 15, 16, 1F
	reg i_clk = 1'b0; // Master clock
	reg i_nrst = 1'b0; // Reset, active low
	reg [7:0] st = 8'h00; // Auto, eq, act, deact, seq, driver, alarm, loss
	reg [4:0] att = 5'h00; // Attenuation code
	reg [6:0] pv = 7'h00; // Event pulses, amplitude down to one second
	reg tx_run = 1'b1; // Transmit clock running
	reg [1:0] tx_div = 2'h0; // Transmit clock divider
	reg [7:0] d; // Read data
	reg [15:0] e; // Expected count
	integer mismatches = 0;
	integer comparisons = 0;
	integer i;
	wire [7:0] i_addr, i_wdata, o_rdata; // Register bus
	wire i_rd, i_wr, o_int_req, o_remote_loop_active; // Strobes and outputs
	// Master clock, 25 ns period
	always #12.5 i_clk = ~i_clk;
	// Transmit clock at a quarter of the master clock, stoppable
	always @(posedge i_clk) begin
		if (tx_run)
			tx_div <= tx_div + 2'h1;
	end
	host_model hst (.i_clk, .o_addr(i_addr), .o_rd(i_rd), .o_wr(i_wr), .o_wdata(i_wdata),
		.i_rdata(o_rdata));
	line_status_regs #(.QUAL_SHORT_CYCLES(28'h0000014), .QUAL_LONG_CYCLES(28'h0000032)) DUT (
		.i_clk, .i_nrst, .i_addr, .i_rd, .i_wr, .i_wdata, .o_rdata, .o_int_req,
		.o_remote_loop_active, .i_auto_remote_loop_enable(st[7]),
		.i_equalizer_out_of_range(st[6]), .i_activate_pattern_ok(st[5]),
		.i_deactivate_pattern_ok(st[4]), .i_test_sequence_locked(st[3]),
		.i_transmit_clock_input(tx_div[1]), .i_driver_short(st[2]),
		.i_alarm_indication(st[1]), .i_signal_loss(st[0]), .i_line_attenuation_code(att),
		.i_amplitude_overflow(pv[6]), .i_jitter_overflow(pv[5]), .i_jitter_underflow(pv[4]),
		.i_sequence_logic_error(pv[3]), .i_excess_zeros(pv[2]), .i_code_violation(pv[1]),
		.i_one_second_tick(pv[0]));
	// Compares a byte
	task chk_byte(input [7:0] got, input [7:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: byte %h, wanted %h", $time, got, exp);
		end
	endtask
	// Compares a single output level
	task chk_bit(input got, input exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("unexpected at %0t: level %b, wanted %b", $time, got, exp);
		end
	endtask
	// Reads a register and compares it
	task rd_chk(input [7:0] a, input [7:0] x);
		hst.rd_reg(a, d);
		chk_byte(d, x);
	endtask
	task tick(input integer n);
		repeat (n) @(posedge i_clk);
	endtask
	// Changes the status levels, then lets them settle
	task drive(input [7:0] s);
		@(posedge i_clk);
		st <= s;
		tick(4);
	endtask
	// One-cycle event pulse
	task pulse(input [6:0] p);
		@(posedge i_clk);
		pv <= p;
		@(posedge i_clk);
		pv <= 7'h00;
	endtask
	task give_verdict;
		$display("comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Watchdog against a hung run
	initial begin
		tick(100000);
		mismatches = mismatches + 1;
		give_verdict;
	end
	// Main sequence
	initial begin
		tick(8);
		i_nrst <= 1'b1;
		tick(4);
		for (i = 0; i < 7; i = i + 1)
			rd_chk(8'h17 + i[7:0], 8'h00);
		drive(8'h4F);
		rd_chk(8'h17, 8'h97);
		rd_chk(8'h19, 8'h00);
		chk_bit(o_int_req, 1'b0);
		drive(8'h00);
		@(posedge i_clk) tx_run <= 1'b0;
		tick(60);
		rd_chk(8'h17, 8'h00);
		tick(20);
		rd_chk(8'h17, 8'h08);
		@(posedge i_clk) tx_run <= 1'b1;
		tick(12);
		rd_chk(8'h17, 8'h00);
		hst.wr_reg(8'h14, 8'hFE);
		drive(8'h01);
		chk_bit(o_int_req, 1'b1);
		rd_chk(8'h19, 8'h01);
		chk_bit(o_int_req, 1'b0);
		rd_chk(8'h19, 8'h00);
		drive(8'h00);
		rd_chk(8'h19, 8'h00);
		hst.wr_reg(8'h16, 8'h01);
		drive(8'h01);
		rd_chk(8'h19, 8'h01);
		drive(8'h00);
		rd_chk(8'h19, 8'h01);
		hst.wr_reg(8'h15, 8'h00);
		hst.wr_reg(8'h17, 8'hFF);
		rd_chk(8'h17, 8'h00);
		for (i = 0; i < 7; i = i + 1) begin
			pulse(7'h01 << i);
			rd_chk(8'h1A, 8'h02 << i);
		end
		hst.wr_reg(8'h13, 8'h01);
		hst.wr_reg(8'h13, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			e = (i == 0) ? 16'h0001 : (i == 1) ? 16'h0002 : (i == 2) ? 16'h0104 : 16'h0106;
			hst.wr_reg(8'h13, {4'h0, i[1:0], 2'h0});
			pulse(7'h08);
			repeat (2) pulse(7'h04);
			repeat (260) pulse(7'h02);
			hst.wr_reg(8'h13, {4'h0, i[1:0], 2'h1});
			tick(2);
			rd_chk(8'h1B, e[7:0]);
			rd_chk(8'h1C, e[15:8]);
		end
		drive(8'h20);
		tick(12);
		rd_chk(8'h17, 8'h00);
		tick(10);
		rd_chk(8'h17, 8'h40);
		chk_bit(o_remote_loop_active, 1'b1);
		rd_chk(8'h18, 8'h20);
		drive(8'h10);
		tick(30);
		rd_chk(8'h17, 8'h20);
		chk_bit(o_remote_loop_active, 1'b0);
		drive(8'hA0);
		tick(30);
		chk_bit(o_remote_loop_active, 1'b0);
		tick(30);
		chk_bit(o_remote_loop_active, 1'b1);
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge i_clk) att <= CODES[19 - 5 * i -: 5];
			tick(4);
			rd_chk(8'h18, {3'h1, CODES[19 - 5 * i -: 5]});
		end
		// Counter wrap: events left from the count runs, then 65534 and one more pair
		rd_chk(8'h1A, 8'h1C);
		hst.wr_reg(8'h13, 8'h0C);
		@(posedge i_clk) pv <= 7'h06;
		tick(32766);
		@(posedge i_clk) pv <= 7'h00;
		rd_chk(8'h1A, 8'h0C);
		pulse(7'h06);
		rd_chk(8'h1A, 8'h0D);
		give_verdict;
	end
endmodule
